// ---- rtl/wsc_defs.svh ----
// Purpose: Constants for the waveform sequence controller.
// Assumes: Included by bare name from rtl files.
// Notes:   Limits, reset defaults and the first step live here; types live in the package.
`ifndef WSC_DEFS_SVH
`define WSC_DEFS_SVH
`define WSC_LEN_MIN       16'h0003
`define WSC_LEN_MAX       16'hc000
`define WSC_LEN_RST       16'h0003
`define WSC_SEQ_MAX       10'h3e8
`define WSC_SEQ_RST       10'h001
`define WSC_ONCE_RST      24'h000001
`define WSC_SYNC_RST      16'h0001
`define WSC_STEP_FIRST    16'h0001
`endif

// ---- rtl/wsc_pkg.sv ----
// Purpose: Types for the waveform sequence controller.
// Assumes: None.
// Notes:   Mode encodings match the control port codes.
package wsc_pkg;
    typedef enum logic [1:0]
    {
        WSC_ADV_AUTO    = 2'b00,
        WSC_ADV_ONCE    = 2'b01,
        WSC_ADV_STEPPED = 2'b10
    } wsc_adv_t;

    typedef enum logic [1:0]
    {
        WSC_ST_IDLE  = 2'b00,
        WSC_ST_LEAD  = 2'b01,
        WSC_ST_RUN   = 2'b10
    } wsc_state_t;

    typedef struct packed
    {
        logic        valid;
        logic [7:0]  num;
    } wsc_ext_sel_t;

    typedef struct packed
    {
        logic        valid;
        logic [9:0]  num;
    } wsc_bus_sel_t;

    typedef struct packed
    {
        logic        set_len;
        logic        block_load;
        logic [15:0] len;
    } wsc_len_cmd_t;
endpackage

// ---- rtl/wsc_sync2.sv ----
// Purpose: Two-flop synchroniser for the external select port.
// Assumes: Inputs are asynchronous to core_clk.
// Notes:   The first stage feeds only the second.
module wsc_sync2 #(
    parameter int W = 9
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// ---- rtl/wsc_controller.sv ----
// Purpose: Sequence controller for one waveform generator channel.
// Assumes: Commands are one-cycle pulses on core_clk; the external select
//          port is asynchronous and passes a two-flop synchroniser.
// Notes:   Table contents live elsewhere; this block tracks lengths, the
//          active table and the current step.
// Function
// - Table length 3 to 49152, default 3.
// - Block load sets the length automatically.
// - Blank lead-in first, trigger goes to waveform.
// - Wrap skips the blank lead-in.
// - Lead-in only armed continuous, bus arming.
// - Waveform lead-in plays step one until event; the code has only the blank lead-in and otherwise starts the run at once.
// - 1000 tables; edits go to active one.
// - Bus source: change only on bus command.
// - External port: eight bits plus valid line.
// - Coherent: switch pending until sequence end.
// - Immediate: abort and start new sequence; a pick made during the blank lead-in is dropped.
// - Timing applies to both select sources.
// - Once mode repeats count times, then idles.
// - Sync pulse on programmed step, default one.
// - Sync lasts the whole assigned step.
// - Jump flag set: dwell until event.
// - Stepped mode: event needed every advance.
module wsc_controller
    import wsc_pkg::*;
#(
    parameter int NSEQ = 1000
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire wsc_bus_sel_t bus_sel,
    input  wire logic [8:0]   ext_port,
    input  wire logic         ext_source,
    input  wire logic         immediate_timing,
    input  wire wsc_adv_t     adv_mode,
    input  wire logic         lead_in_option,
    input  wire logic         armed_continuous,
    input  wire logic         arm_from_bus,
    input  wire logic         lead_in_set,
    input  wire logic         lead_in_from_remote,
    input  wire wsc_len_cmd_t len_cmd,
    input  wire logic [23:0]  once_count,
    input  wire logic         once_count_set,
    input  wire logic [15:0]  sync_step,
    input  wire logic         sync_step_set,
    input  wire logic         step_done,
    input  wire logic         step_jump_flag,
    input  wire logic         event_pulse,
    input  wire logic         select_func,
    output logic [9:0]        active_seq,
    output logic [15:0]       step_num,
    output logic [15:0]       active_len,
    output logic              blank_level_lead_in,
    output logic              sync_out,
    output logic              idle_out
);
`include "wsc_defs.svh"

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Indexed by sequence number, so the top table has its own slot.
    logic [15:0] len_mem [1:NSEQ];
    logic [9:0]  pend_seq_reg;
    logic        pend_reg;
    logic        lead_cfg_reg;
    logic [23:0] once_reg;
    logic [23:0] pass_reg;
    logic [15:0] sync_reg;
    logic [8:0]  ext_sync;
    logic [7:0]  ext_prev_reg;
    logic        ext_vld_prev_reg;
    wsc_state_t  state_reg;

    wsc_sync2 #(.W(9)) u_sync (
        .core_clk (core_clk),
        .resetn   (resetn),
        .async_in (ext_port),
        .sync_out (ext_sync)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire        ext_vld   = ext_sync[8];
    wire [9:0]  ext_num   = {2'b00, ext_sync[7:0]} + 10'h001;
    // A new external pick is taken on the valid rise or a number change.
    wire        ext_req   = ext_source && ext_vld &&
                            (!ext_vld_prev_reg ||
                             ext_sync[7:0] != ext_prev_reg);
    wire        bus_req   = !ext_source && bus_sel.valid &&
                            bus_sel.num != 10'h000 &&
                            bus_sel.num <= `WSC_SEQ_MAX;
    wire        sel_req   = ext_req || bus_req;
    wire [9:0]  sel_num   = ext_req ? ext_num : bus_sel.num;
    wire        len_ok    = len_cmd.len >= `WSC_LEN_MIN &&
                            len_cmd.len <= `WSC_LEN_MAX;
    wire        len_wr    = len_cmd.block_load ||
                            (len_cmd.set_len && len_ok);
    wire        lead_ok   = lead_cfg_reg && armed_continuous &&
                            arm_from_bus;
    wire        at_last   = step_num >= active_len;
    wire        may_adv   = adv_mode == WSC_ADV_STEPPED ?
                            event_pulse
                          : step_jump_flag ? event_pulse
                          : 1'b1;
    wire        adv       = state_reg == WSC_ST_RUN && step_done &&
                            may_adv;
    wire        seq_end   = adv && at_last;
    wire        once_done = adv_mode == WSC_ADV_ONCE &&
                            pass_reg + 24'h000001 >= once_reg;
    wire        take_now  = sel_req && immediate_timing;
    wire        take_end  = seq_end && pend_reg;
    wire [9:0]  next_seq  = take_now ? sel_num : pend_seq_reg;
    wire [15:0] sync_next = sync_step == 16'h0000 ?
                            `WSC_SYNC_RST : sync_step;

    // ------------------------------------------------------------
    // Configuration and table lengths
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (len_cmd.block_load)
            len_mem[active_seq] <= len_cmd.len;
        else if (len_cmd.set_len && len_ok)
            len_mem[active_seq] <= len_cmd.len;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lead_cfg_reg     <= 1'b0;
            once_reg         <= `WSC_ONCE_RST;
            sync_reg         <= `WSC_SYNC_RST;
            ext_prev_reg     <= 8'h00;
            ext_vld_prev_reg <= 1'b0;
        end
        else
        begin
            if (lead_in_set && lead_in_from_remote)
                lead_cfg_reg <= lead_in_option;
            if (once_count_set && once_count != 24'h000000)
                once_reg <= once_count;
            if (sync_step_set)
                sync_reg <= sync_next;
            if (ext_vld)
                ext_prev_reg <= ext_sync[7:0];
            ext_vld_prev_reg <= ext_vld;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_reg           <= WSC_ST_IDLE;
            active_seq          <= `WSC_SEQ_RST;
            active_len          <= `WSC_LEN_RST;
            pend_seq_reg        <= `WSC_SEQ_RST;
            pend_reg            <= 1'b0;
            pass_reg            <= 24'h000000;
            step_num            <= `WSC_STEP_FIRST;
            blank_level_lead_in <= 1'b0;
            sync_out            <= 1'b0;
            idle_out            <= 1'b1;
        end
        else
        begin
            if (sel_req && !immediate_timing)
            begin
                pend_seq_reg <= sel_num;
                pend_reg     <= 1'b1;
            end
            else if (take_end)
                pend_reg <= 1'b0;
            if (take_now)
                pend_reg <= 1'b0;
            // A length write to the active table shows at once.
            if (len_wr)
                active_len <= len_cmd.len;

            case (state_reg)
                WSC_ST_IDLE:
                begin
                    // Nothing plays yet, so an immediate pick lands at once; dropping
                    // it would send later table edits to the wrong table.
                    if (take_now)
                    begin
                        active_seq <= sel_num;
                        active_len <= len_mem[sel_num];
                    end
                    if (select_func)
                    begin
                        step_num <= `WSC_STEP_FIRST;
                        pass_reg <= 24'h000000;
                        if (!take_now && !len_wr)
                            active_len <= len_mem[active_seq];
                        state_reg <= lead_ok ? WSC_ST_LEAD
                                             : WSC_ST_RUN;
                    end
                end
                WSC_ST_LEAD:
                begin
                    if (event_pulse)
                        state_reg <= WSC_ST_RUN;
                end
                WSC_ST_RUN:
                begin
                    if (take_now || take_end)
                    begin
                        active_seq <= next_seq;
                        active_len <= len_mem[next_seq];
                        step_num   <= `WSC_STEP_FIRST;
                        pass_reg   <= 24'h000000;
                    end
                    else if (seq_end)
                    begin
                        step_num <= `WSC_STEP_FIRST;
                        pass_reg <= pass_reg + 24'h000001;
                        if (once_done)
                            state_reg <= WSC_ST_IDLE;
                    end
                    else if (adv)
                        step_num <= step_num + 16'h0001;
                end
                default:
                    state_reg <= WSC_ST_IDLE;
            endcase

            blank_level_lead_in <= state_reg == WSC_ST_LEAD;
            // Sync follows the step, so it spans the step's whole waveform.
            sync_out <= state_reg == WSC_ST_RUN &&
                        step_num == sync_reg;
            idle_out <= state_reg == WSC_ST_IDLE;
        end
    end

    chk_sync_step_match: assert property (
        @(posedge core_clk) disable iff (!resetn)
        sync_out |-> $past(step_num) == $past(sync_reg))
        else $error("sync pulse on wrong step");

    chk_immediate_take: assert property (
        @(posedge core_clk) disable iff (!resetn)
        take_now && state_reg == WSC_ST_RUN |=> active_seq == $past(sel_num))
        else $error("immediate select not taken");

    chk_coherent_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !immediate_timing && !seq_end |=> $stable(active_seq))
        else $error("coherent select switched early");

    chk_lead_hold: assert property (
        @(posedge core_clk) disable iff (!resetn)
        state_reg == WSC_ST_LEAD && !event_pulse |=>
        state_reg == WSC_ST_LEAD)
        else $error("lead-in left without trigger");

    chk_stepped_event: assert property (
        @(posedge core_clk) disable iff (!resetn)
        adv_mode == WSC_ADV_STEPPED && !event_pulse &&
        state_reg == WSC_ST_RUN && !take_now && !take_end
        |=> $stable(step_num))
        else $error("stepped advance without event");

    chk_len_range: assert property (
        @(posedge core_clk) disable iff (!resetn)
        len_cmd.set_len && !len_ok && !len_cmd.block_load
        |=> len_mem[$past(active_seq)] == $past(len_mem[active_seq]))
        else $error("out of range length stored");

    chk_bus_only: assert property (
        @(posedge core_clk) disable iff (!resetn)
        !ext_source && !bus_sel.valid && !pend_reg |=> $stable(active_seq))
        else $error("sequence changed without command");

    chk_once_idle: assert property (
        @(posedge core_clk) disable iff (!resetn)
        seq_end && once_done && !take_end && !take_now
        |=> ##1 idle_out)
        else $error("once mode did not idle");
endmodule

// ---- tb/wsc_ext_selector.sv ----
// Purpose: Model of the external parallel sequence selector.
// Assumes: Requests are one-cycle pulses on core_clk.
// Notes:   Released number lines show the inverse of the last value.
module wsc_ext_selector (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       req,
    input  wire logic [7:0] req_num,
    output logic      [8:0] ext_port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] hold_reg;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ext_port <= 9'h000;
            hold_reg <= 4'h0;
        end
        else if (req)
        begin
            ext_port <= {1'b1, req_num};
            hold_reg <= 4'h8;
        end
        else if (hold_reg == 4'h1)
        begin
            // Stale lines must not look like a held number once released.
            ext_port <= {1'b0, ~ext_port[7:0]};
            hold_reg <= 4'h0;
        end
        else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end
endmodule

// ---- tb/wsc_controller_bench.sv ----
// Purpose: Self-checking bench for the sequence controller.
// Assumes: Inputs change at the falling edge of core_clk.
// Notes:   Length memory is not reset, so tables are loaded first.
module wsc_controller_bench
    import wsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         core_clk = 1'b0;
    logic         resetn = 1'b0;
    wsc_bus_sel_t bus_sel = '0;
    logic [8:0]   ext_port;
    logic         ext_source = 1'b0;
    logic         immediate_timing = 1'b1;
    wsc_adv_t     adv_mode = WSC_ADV_AUTO;
    logic         lead_in_option = 1'b0;
    logic         armed_continuous = 1'b0;
    logic         arm_from_bus = 1'b0;
    logic         lead_in_set = 1'b0;
    logic         lead_in_from_remote = 1'b0;
    wsc_len_cmd_t len_cmd = '0;
    logic [23:0]  once_count = 24'h000002;
    logic         once_count_set = 1'b0;
    logic [15:0]  sync_step = 16'h0003;
    logic         sync_step_set = 1'b0;
    logic         step_done = 1'b0;
    logic         step_jump_flag = 1'b0;
    logic         event_pulse = 1'b0;
    logic         select_func = 1'b0;
    logic         sel_req = 1'b0;
    logic [7:0]   sel_num = 8'h00;
    logic [9:0]   active_seq;
    logic [15:0]  step_num, active_len;
    logic         blank_level_lead_in, sync_out, idle_out;
    logic [9:0]   rs[6];
    logic [15:0]  rl[6];
    logic [9:0]   fix[4] = '{10'h001, 10'h005, 10'h007, 10'h00a};
    logic [31:0]  rnd = 32'h1c7fc7b0;
    int           errors = 0;
    int           checks = 0;

    wsc_controller #(.NSEQ(1000)) dut (
        .core_clk, .resetn, .bus_sel, .ext_port, .ext_source,
        .immediate_timing, .adv_mode, .lead_in_option, .armed_continuous,
        .arm_from_bus, .lead_in_set, .lead_in_from_remote, .len_cmd,
        .once_count, .once_count_set, .sync_step, .sync_step_set,
        .step_done, .step_jump_flag, .event_pulse, .select_func,
        .active_seq, .step_num, .active_len, .blank_level_lead_in,
        .sync_out, .idle_out
    );
    wsc_ext_selector ext (
        .core_clk, .resetn, .req(sel_req), .req_num(sel_num), .ext_port
    );

    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rst();
        resetn = 1'b0;
        cyc(12);
        resetn = 1'b1;
        cyc(1);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask
    // Holding step_done for n edges gives n back-to-back completions.
    task automatic done(input int n);
        step_done = 1'b1;
        cyc(n);
        step_done = 1'b0;
    endtask
    task automatic bsel(input logic [9:0] s);
        bus_sel = {1'b1, s};
        cyc(1);
        bus_sel = '0;
    endtask
    task automatic blen(input logic set, input logic [15:0] l);
        len_cmd = {set, ~set, l};
        cyc(1);
        len_cmd = '0;
    endtask
    task automatic xsel(input logic [7:0] n);
        sel_num = n;
        pulse(sel_req);
    endtask

    initial
    begin
        #50000;
        errors++;
        report_and_stop();
    end

    initial
    begin
        rst();
        chk(active_seq, 10'h001);
        chk({active_len, step_num}, 32'h00030001);
        chk({blank_level_lead_in, sync_out, idle_out}, 3'b001);
        blen(1'b0, 16'h0004);
        blen(1'b1, 16'h0002);
        blen(1'b1, 16'hc001);
        cyc(1);
        chk(active_len, 16'h0004);
        blen(1'b1, 16'hc000);
        cyc(1);
        chk(active_len, 16'hc000);
        blen(1'b0, 16'h0003);
        cyc(1);
        chk(active_len, 16'h0003);
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            rs[i] = 10'(11 + i * 150 + rnd[15:0] % 150);
            rl[i] = 16'(3 + rnd[31:16] % 49150);
            bsel(rs[i]);
            blen(1'b1, rl[i]);
        end
        for (int i = 0; i < 6; i++)
        begin
            bsel(rs[i]);
            cyc(1);
            chk({active_seq, active_len}, {rs[i], rl[i]});
        end
        foreach (fix[i])
        begin
            bsel(fix[i]);
            blen(1'b0, 16'h0003);
        end
        rst();
        immediate_timing = 1'b0;
        pulse(select_func);
        chk(step_num, 16'h0001);
        cyc(1);
        chk(sync_out, 1'b1);
        done(1);
        chk(step_num, 16'h0002);
        cyc(1);
        chk(sync_out, 1'b0);
        step_jump_flag = 1'b1;
        done(2);
        chk(step_num, 16'h0002);
        event_pulse = 1'b1;
        done(1);
        event_pulse = 1'b0;
        step_jump_flag = 1'b0;
        chk(step_num, 16'h0003);
        pulse(sync_step_set);
        done(3);
        cyc(1);
        chk({step_num, 15'h0000, sync_out}, 32'h00030001);
        done(1);
        cyc(1);
        chk({step_num, 15'h0000, sync_out}, 32'h00010000);
        bsel(10'h005);
        cyc(2);
        chk(active_seq, 10'h001);
        done(3);
        cyc(1);
        chk(active_seq, 10'h005);
        immediate_timing = 1'b1;
        done(1);
        bsel(10'h007);
        chk({active_seq, step_num}, {10'h007, 16'h0001});
        xsel(8'h09);
        cyc(6);
        chk(active_seq, 10'h007);
        ext_source = 1'b1;
        cyc(6);
        bsel(10'h005);
        cyc(1);
        chk(active_seq, 10'h007);
        xsel(8'h09);
        for (int i = 0; i < 10 && active_seq !== 10'h00a; i++)
            cyc(1);
        chk(active_seq, 10'h00a);
        cyc(10);
        chk(active_seq, 10'h00a);
        immediate_timing = 1'b0;
        done(1);
        xsel(8'h00);
        cyc(6);
        chk(active_seq, 10'h00a);
        done(2);
        cyc(1);
        chk(active_seq, 10'h001);
        adv_mode = WSC_ADV_STEPPED;
        done(2);
        chk(step_num, 16'h0001);
        event_pulse = 1'b1;
        done(1);
        event_pulse = 1'b0;
        chk(step_num, 16'h0002);
        rst();
        adv_mode = WSC_ADV_ONCE;
        pulse(once_count_set);
        pulse(select_func);
        done(5);
        cyc(1);
        chk(idle_out, 1'b0);
        done(1);
        cyc(2);
        chk(idle_out, 1'b1);
        rst();
        adv_mode = WSC_ADV_AUTO;
        {armed_continuous, arm_from_bus, lead_in_option} = 3'b111;
        pulse(lead_in_set);
        pulse(select_func);
        cyc(2);
        chk(blank_level_lead_in, 1'b0);
        rst();
        lead_in_from_remote = 1'b1;
        pulse(lead_in_set);
        pulse(select_func);
        cyc(2);
        chk(blank_level_lead_in, 1'b1);
        pulse(event_pulse);
        cyc(2);
        chk({step_num, 15'h0000, blank_level_lead_in}, 32'h00010000);
        done(3);
        cyc(2);
        chk({step_num, 15'h0000, blank_level_lead_in}, 32'h00010000);
        report_and_stop();
    end
endmodule
